// ---- logic/oct_pkg.sv ----
/*
  Shared constants and types of the octal driver control block: command word
  layout, selector codes, reset values, filter timing and the fault carrier.
  Assumes a 125 MHz reference clock; timing counts derive from it.
*/
package oct_pkg;

  // ==========================================================================
  // Channel and word geometry
  // ==========================================================================
  localparam int          NUM_CH       = 8;
  localparam int          WORD_BITS    = 16;
  localparam int          BITCNT_W     = 4;
  localparam int          KEY_MSB      = 15;
  localparam int          KEY_LSB      = 12;
  localparam int          SEL_MSB      = 11;
  localparam int          SEL_LSB      = 8;
  localparam int          DIRECT_LO    = 5;  // Channels six to eight are indices 5..7

  // ==========================================================================
  // Command codes
  // ==========================================================================
  localparam logic [3:0]  KEY_VALID    = 4'ha;
  localparam logic [3:0]  SEL_OUTPUT   = 4'hc;
  localparam logic [3:0]  SEL_DIAG     = 4'h3;
  localparam logic [3:0]  SEL_PROTECT  = 4'ha;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [7:0]  CMD_RST      = 8'h00;  // All channels off
  localparam logic [7:0]  DIAG_RST     = 8'h00;  // No-latch diagnosis
  localparam logic [7:0]  PROT_RST     = 8'h00;  // Switch-off overcurrent protection
  localparam logic [15:0] FAULT_RST    = 16'h0000;

  // ==========================================================================
  // Timing
  // ==========================================================================
  localparam int          CLK_MHZ      = 125;
  localparam int          FILT_MIN_US  = 5;
  localparam int          FILT_MAX_US  = 20;
  localparam int          FILT_MIN_CYC = FILT_MIN_US * CLK_MHZ;
  localparam int          FILT_MAX_CYC = FILT_MAX_US * CLK_MHZ;
  localparam int          FILT_CNT_W   = 12;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef enum logic [0:0] {
    OCT_LNK_FAULT = 1'b0,  // Shifting out the fault snapshot
    OCT_LNK_WRAP  = 1'b1   // Echoing serial input delayed by one word
  } oct_lnk_state_t;

  // Raw comparator flags from the analog channel cells, one bit per channel
  typedef struct packed {
    logic [7:0] overcurrent;
    logic [7:0] overtemp;
    logic [7:0] open_load;
    logic [7:0] short_gnd;
    logic [7:0] short_bat;
    logic [7:0] high_side;
  } oct_fault_raw_t;

endpackage

// ---- logic/oct_sync.sv ----
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; multi-bit coherence is not kept.
*/
`timescale 1ns/1ps
module oct_sync #(
  parameter int             W       = 1,
  parameter logic [W-1:0]   RST_VAL = '0
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  // Levels
  input  wire logic [W-1:0] async_i,
  output logic      [W-1:0] sync_o
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta_q <= RST_VAL;
      sync_o <= RST_VAL;
    end else begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// ---- logic/oct_filter.sv ----
/*
  Per-bit persistence filter: an output rises once its input has been high
  for FILT_CYC consecutive cycles and falls as soon as the input drops.
  Assumes inputs are already synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module oct_filter #(
  parameter int             N        = 8,
  parameter int             CNT_W    = 12,
  parameter int             FILT_CYC = 625
) (
  // Clock and reset
  input  wire logic         ref_clk_i,
  input  wire logic         arst_n_i,
  input  wire logic         clear_i,
  // Flags
  input  wire logic [N-1:0] raw_i,
  output logic      [N-1:0] filt_o
);

  localparam logic [CNT_W-1:0] LIMIT = CNT_W'(FILT_CYC - 1);

  logic [CNT_W-1:0] cnt_q [N];

  // One counter per flag; a dropout restarts the whole wait
  for (genvar i = 0; i < N; i++) begin : g_bit
    always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        cnt_q[i]  <= '0;
        filt_o[i] <= 1'b0;
      end else if (clear_i || !raw_i[i]) begin
        cnt_q[i]  <= '0;
        filt_o[i] <= 1'b0;
      end else if (cnt_q[i] == LIMIT) begin
        filt_o[i] <= 1'b1;
      end else begin
        cnt_q[i]  <= cnt_q[i] + CNT_W'(1);
      end
    end
  end

endmodule

// ---- logic/oct_driver.sv ----
/*
  Control logic of an eight-channel self-configuring driver: serial command
  port on its own clock, direct enables for channels six to eight, protection
  mode selection, fault filtering and the fault register.
  Assumes the analog cells deliver raw fault flags and act on the channel
  controls; pull-ups and pull-downs on pins are outside this logic.
*/
`timescale 1ns/1ps

module oct_driver
  import oct_pkg::*;
#(
  parameter int FILT_CYC = FILT_MIN_CYC
) (
  // Reference clock and power-on reset
  input  wire logic                 ref_clk_i,
  input  wire logic                 arst_n_i,
  // Reset pin
  input  wire logic                 res_n_i,
  // Serial port, link clock domain
  input  wire logic                 sclk_i,
  input  wire logic                 cs_n_i,
  input  wire logic                 serial_in_i,
  output logic                      serial_out_o,
  output logic                      serial_out_oe_o,
  // Direct enables
  input  wire logic                 direct_enable_ch6_i,
  input  wire logic                 direct_enable_ch7_i,
  input  wire logic                 direct_enable_ch8_i,
  // Analog channel cells
  input  wire oct_pkg::oct_fault_raw_t fault_raw_i,
  output logic [NUM_CH-1:0]         power_channel_o,
  output logic [NUM_CH-1:0]         current_limit_en_o,
  // Status
  output logic [WORD_BITS-1:0]      fault_flags_o
);

  import oct_pkg::*;

  // ==========================================================================
  // Link clock domain
  // ==========================================================================
  logic [BITCNT_W-1:0]  bit_cnt_q;
  oct_lnk_state_t       lnk_state_q;
  logic [WORD_BITS-1:0] shift_q;
  logic [WORD_BITS-1:0] rx_word_q;
  logic                 key_ok_q;
  logic                 frame_ok_q;
  logic                 out_started_q;
  logic                 dout_q;
  logic [WORD_BITS-1:0] snap_q;
  logic                 frm_tgl_q;

  wire                  lnk_rst_n  = arst_n_i & ~cs_n_i;
  wire [WORD_BITS-1:0]  shift_next = {serial_in_i, shift_q[WORD_BITS-1:1]};
  wire                  word_end   = (bit_cnt_q == BITCNT_W'(WORD_BITS - 1));
  wire                  new_key_ok = (shift_next[KEY_MSB:KEY_LSB] == KEY_VALID);
  wire                  frm_first  = (lnk_state_q == OCT_LNK_FAULT) && (bit_cnt_q == '0);

  // Frame position; chip select high holds it at the frame start
  always_ff @(posedge sclk_i or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      bit_cnt_q   <= '0;
      lnk_state_q <= OCT_LNK_FAULT;
    end else begin
      bit_cnt_q <= bit_cnt_q + BITCNT_W'(1);
      case (lnk_state_q)
        OCT_LNK_FAULT: begin
          if (word_end) begin
            lnk_state_q <= OCT_LNK_WRAP;
          end
        end
        OCT_LNK_WRAP: lnk_state_q <= OCT_LNK_WRAP;
        default:      lnk_state_q <= OCT_LNK_FAULT;
      endcase
    end
  end

  // Capture on rising edge; these survive chip select so the core can read them
  always_ff @(posedge sclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_q    <= '0;
      rx_word_q  <= '0;
      key_ok_q   <= 1'b0;
      frame_ok_q <= 1'b0;
      frm_tgl_q  <= 1'b0;
    end else begin
      shift_q <= shift_next;
      frm_tgl_q <= frm_tgl_q ^ frm_first;
      if (word_end && lnk_state_q == OCT_LNK_FAULT) begin
        rx_word_q <= shift_next;
        key_ok_q  <= new_key_ok;
      end
      // Only true when this edge closes a whole word of a keyed frame
      frame_ok_q <= word_end && ((lnk_state_q == OCT_LNK_FAULT) ? new_key_ok : key_ok_q);
    end
  end

  // Output changes on falling edge: fault snapshot first, then echo of input
  always_ff @(negedge sclk_i or negedge lnk_rst_n) begin
    if (!lnk_rst_n) begin
      out_started_q <= 1'b0;
      dout_q        <= 1'b0;
    end else begin
      out_started_q <= 1'b1;
      dout_q        <= (lnk_state_q == OCT_LNK_WRAP) ? shift_q[0] : snap_q[bit_cnt_q];
    end
  end

  // Bit zero shows before the first falling edge
  assign serial_out_o    = out_started_q ? dout_q : snap_q[0];
  assign serial_out_oe_o = ~cs_n_i;

  // ==========================================================================
  // Pin synchronisers
  // ==========================================================================
  localparam int                       SYNC_W   = 5 + $bits(oct_fault_raw_t);
  localparam logic [SYNC_W-1:0]        SYNC_RST = {1'b1, 1'b0, 3'h0, {$bits(oct_fault_raw_t){1'b0}}};

  logic [SYNC_W-1:0] sync_vec;
  logic              cs_n_s;
  logic              res_n_s;
  logic [2:0]        direct_s;
  oct_fault_raw_t    raw_s;

  // Pins and analog flags cross before any core-clock logic reads them; the link and output enable use cs_n_i directly
  oct_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .async_i   ({cs_n_i, res_n_i, direct_enable_ch8_i, direct_enable_ch7_i,
                 direct_enable_ch6_i, fault_raw_i}),
    .sync_o    (sync_vec)
  );

  assign {cs_n_s, res_n_s, direct_s, raw_s} = sync_vec;

  // ==========================================================================
  // Frame end and command decode
  // ==========================================================================
  logic cs_prev_q;
  logic frm_seen_q;

  // Starts high so the release of power-on reset is not taken as a frame end
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cs_prev_q <= 1'b1;
    end else begin
      cs_prev_q <= cs_n_s;
    end
  end

  // Link registers are still while chip select is high, so reading them here is safe
  wire       frame_end = cs_n_s & ~cs_prev_q;
  wire       fresh     = frm_tgl_q ^ frm_seen_q;
  wire       apply     = frame_end & frame_ok_q & fresh;
  wire [3:0] sel       = rx_word_q[SEL_MSB:SEL_LSB];
  wire [7:0] data      = rx_word_q[NUM_CH-1:0];
  wire       wr_cmd    = apply & (sel == SEL_OUTPUT);
  wire       wr_diag   = apply & (sel == SEL_DIAG);
  wire       wr_prot   = apply & (sel == SEL_PROTECT);
  wire       soft_rst  = ~res_n_s;

  // A frame with no clocks leaves the toggle alone, so the last verdict is not reused
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      frm_seen_q <= 1'b0;
    end else if (frame_end) begin
      frm_seen_q <= frm_tgl_q;
    end
  end

  // ==========================================================================
  // Configuration registers
  // ==========================================================================
  logic [NUM_CH-1:0] cmd_q;
  logic [NUM_CH-1:0] diag_latch_q;
  logic [NUM_CH-1:0] prot_q;

  // Power-on and reset pin both restore defaults
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_q        <= CMD_RST;
      diag_latch_q <= DIAG_RST;
      prot_q       <= PROT_RST;
    end else if (soft_rst) begin
      cmd_q        <= CMD_RST;
      diag_latch_q <= DIAG_RST;
      prot_q       <= PROT_RST;
    end else begin
      if (wr_cmd) cmd_q <= data;
      if (wr_diag) diag_latch_q <= data;
      if (wr_prot) prot_q <= data;
    end
  end

  // ==========================================================================
  // Channel command and fault detection
  // ==========================================================================
  // Direct enables OR'd into the top three channels; an open pin reads low outside
  wire [NUM_CH-1:0] direct_vec = {direct_s, {DIRECT_LO{1'b0}}};
  wire [NUM_CH-1:0] eff_cmd    = cmd_q | direct_vec;

  // Off-state checks pick the short polarity from the detected wiring
  wire [NUM_CH-1:0] short_sel  = (raw_s.high_side & raw_s.short_bat) |
                                 (~raw_s.high_side & raw_s.short_gnd);
  wire [NUM_CH-1:0] off_raw    = (raw_s.open_load | short_sel) & ~eff_cmd;

  logic [NUM_CH-1:0] filt_oc;
  logic [NUM_CH-1:0] filt_ot;
  logic [NUM_CH-1:0] filt_off;

  // Filter adds to the two-cycle synchroniser, still inside the window near its lower end
  oct_filter #(
    .N        (3 * NUM_CH),
    .CNT_W    (FILT_CNT_W),
    .FILT_CYC (FILT_CYC)
  ) u_filter (
    .ref_clk_i (ref_clk_i),
    .arst_n_i  (arst_n_i),
    .clear_i   (soft_rst),
    .raw_i     ({off_raw, raw_s.overtemp, raw_s.overcurrent}),
    .filt_o    ({filt_off, filt_ot, filt_oc})
  );

  // ==========================================================================
  // Fault register and protection state
  // ==========================================================================
  logic [WORD_BITS-1:0] fault_q;
  logic [NUM_CH-1:0]    oc_off_q;

  wire [WORD_BITS-1:0] fault_new  = {filt_off, filt_oc | filt_ot};
  wire [WORD_BITS-1:0] latch16    = {diag_latch_q, diag_latch_q};
  // New events win over a clear arriving in the same cycle
  wire [WORD_BITS-1:0] fault_d    = fault_new | (fault_q & latch16 & ~{WORD_BITS{apply}});
  wire [NUM_CH-1:0]    oc_off_d   = (filt_oc & ~prot_q) | (oc_off_q & ~{NUM_CH{apply}});

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      fault_q  <= FAULT_RST;
      oc_off_q <= '0;
    end else if (soft_rst) begin
      fault_q  <= FAULT_RST;
      oc_off_q <= '0;
    end else begin
      fault_q  <= fault_d;
      oc_off_q <= oc_off_d;
    end
  end

  // Snapshot frozen while chip select is low so the link shifts a steady word
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      snap_q <= FAULT_RST;
    end else if (cs_n_s) begin
      snap_q <= fault_q;
    end
  end

  // ==========================================================================
  // Channel drive
  // ==========================================================================
  logic [NUM_CH-1:0] power_q;
  logic [NUM_CH-1:0] ilim_q;

  // Thermal cut uses the unfiltered flag so each hot channel drops at once
  wire [NUM_CH-1:0] drive_d = eff_cmd & ~raw_s.overtemp & ~oc_off_q;

  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      power_q <= '0;
      ilim_q  <= PROT_RST;
    end else begin
      power_q <= soft_rst ? '0 : drive_d;
      ilim_q  <= prot_q;
    end
  end

  assign power_channel_o    = power_q;
  assign current_limit_en_o = ilim_q;
  assign fault_flags_o      = fault_q;

endmodule

// ---- tb/oct_driver_asserts.sv ----
/*
  Port checker for the octal driver control block.
  Assumes it is bound to oct_driver and sees only its ports.
*/
`timescale 1ns/1ps
module oct_driver_asserts
  import oct_pkg::*;
#(
  parameter int FILT_CYC = 8
) (
  // Clocks and resets
  input wire logic                   ref_clk_i,
  input wire logic                   arst_n_i,
  input wire logic                   res_n_i,
  // Serial port
  input wire logic                   sclk_i,
  input wire logic                   cs_n_i,
  input wire logic                   serial_in_i,
  input wire logic                   serial_out_o,
  input wire logic                   serial_out_oe_o,
  // Direct enables
  input wire logic                   direct_enable_ch6_i,
  input wire logic                   direct_enable_ch7_i,
  input wire logic                   direct_enable_ch8_i,
  // Channel cells and status
  input wire oct_pkg::oct_fault_raw_t fault_raw_i,
  input wire logic [NUM_CH-1:0]      power_channel_o,
  input wire logic [NUM_CH-1:0]      current_limit_en_o,
  input wire logic [WORD_BITS-1:0]   fault_flags_o
);
  import oct_pkg::*;
  logic [15:0] hot_q;
  wire         dir6_clean = direct_enable_ch6_i && res_n_i && !fault_raw_i.overtemp[5]
                            && !fault_raw_i.overcurrent[5];
  // ==========================================================================
  // Helper: consecutive cycles of a raw on-state fault on channel one
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      hot_q <= 16'h0000;
    end else if (!(fault_raw_i.overcurrent[0] | fault_raw_i.overtemp[0]) || !res_n_i) begin
      hot_q <= 16'h0000;
    end else if (hot_q != 16'hffff) begin
      hot_q <= hot_q + 16'h0001;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);
  // ==========================================================================
  // Assertions
  // ==========================================================================
  oe_follows_a: assert property (serial_out_oe_o == !cs_n_i)
    else $error("serial output enable does not follow chip select");
  res_clears_a: assert property ((!res_n_i)[*4] |-> power_channel_o == '0 && fault_flags_o == '0)
    else $error("reset pin low left a channel or fault bit set");
  direct_on_a: assert property (dir6_clean[*5] |-> power_channel_o[5])
    else $error("direct enable high did not turn its channel on");
  direct_sync_a: assert property ($rose(direct_enable_ch8_i) && !power_channel_o[7] |=> !power_channel_o[7])
    else $error("direct enable reached the channel without synchronising");
  hot_off_a: assert property ($stable(fault_raw_i.overtemp)[*4] |-> (power_channel_o & fault_raw_i.overtemp) == '0)
    else $error("over-temperature channel still on");
  mode_hold_a: assert property ((!cs_n_i && res_n_i)[*6] |-> $stable(current_limit_en_o))
    else $error("protection mode changed inside a frame");
  filt_min_a: assert property ($rose(fault_flags_o[0]) |-> hot_q >= FILT_CYC)
    else $error("fault bit set before the filter time");
  filt_max_a: assert property (hot_q == 16'(FILT_CYC + 6) |-> fault_flags_o[0])
    else $error("fault bit late after the filter time");
  off_diag_a: assert property ($rose(fault_flags_o[12]) |-> !power_channel_o[4])
    else $error("off-state fault flagged while channel on");
  // Main scenarios reached
  direct_cv: cover property ($rose(power_channel_o[7]));
  limit_cv: cover property ($rose(current_limit_en_o[0]));
  offdiag_cv: cover property ($rose(fault_flags_o[12]));
endmodule

bind oct_driver oct_driver_asserts #(.FILT_CYC(FILT_CYC)) chk_u (.*);

// ---- tb/oct_host.sv ----
/*
  Host microcontroller model driving the serial port of the driver.
  Assumes its link clock is unrelated to the core clock; clock idles low.
*/
`timescale 1ns/1ps
module oct_host (
  // Serial lines to the device
  output logic            sclk_o,
  output logic            cs_n_o,
  output logic            sdo_o,
  // Serial data back from the device
  input  wire logic       sdi_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdo_o  = 1'b0;
  end
  // ==========================================================================
  // One frame: nb bits LSB first, 64 ns link period, answer sampled on rise
  // ==========================================================================
  task automatic xfer(input logic [31:0] wd, input int nb, output logic [31:0] rx);
    rx = '0;
    #13 cs_n_o = 1'b0; // Odd offset keeps the link out of phase with the core
    #64;
    for (int k = 0; k < nb; k++) begin
      sdo_o = wd[k];
      #32 sclk_o = 1'b1;
      rx[k] = sdi_i;
      #32 sclk_o = 1'b0;
    end
    #32 cs_n_o = 1'b1;
    sdo_o = 1'b1; // Released data line floats to its pull-up level
  endtask
endmodule

// ---- tb/testbench.sv ----
/*
  Self-checking bench for the octal driver control block.
  Assumes the host model for the serial port and a shortened fault filter.
*/
`timescale 1ns/1ps
module testbench;
  import oct_pkg::*;
  localparam int FC = 8;
  logic           ref_clk_i = 1'b0;
  logic           arst_n_i  = 1'b0;
  logic           res_n_i   = 1'b1;
  logic           sclk_i, cs_n_i, serial_in_i, serial_out_o, serial_out_oe_o;
  logic [2:0]     den       = 3'h0;
  oct_fault_raw_t fr        = '0;
  logic [7:0]     pwr, lim;
  logic [15:0]    flt;
  logic [31:0]    rd;
  int             n_errors  = 0;
  int             checks    = 0;
  int             cyc       = 0;
  always #4 ref_clk_i = ~ref_clk_i;
  oct_driver #(.FILT_CYC(FC)) dut_u (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .res_n_i(res_n_i),
    .sclk_i(sclk_i), .cs_n_i(cs_n_i), .serial_in_i(serial_in_i), .serial_out_o(serial_out_o),
    .serial_out_oe_o(serial_out_oe_o), .direct_enable_ch6_i(den[0]), .direct_enable_ch7_i(den[1]),
    .direct_enable_ch8_i(den[2]), .fault_raw_i(fr), .power_channel_o(pwr),
    .current_limit_en_o(lim), .fault_flags_o(flt));
  oct_host host_u (.sclk_o(sclk_i), .cs_n_o(cs_n_i), .sdo_o(serial_in_i), .sdi_i(serial_out_o));
  // ==========================================================================
  // Shared tasks
  // ==========================================================================
  task automatic wrap_up();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic wr(input logic [15:0] w);
    host_u.xfer({16'h0000, w}, 16, rd);
    tick(8);
  endtask
  // Hang guard, far above the expected run length
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_errors++;
      wrap_up();
    end
  end
  // ==========================================================================
  // Main sequence
  // ==========================================================================
  initial begin
    tick(5);
    arst_n_i = 1'b1;
    tick(4);
    chk(pwr, 8'h00);
    chk(lim, 8'h00);
    wr(16'hacff);
    chk(pwr, 8'hff);
    chk({15'h0000, serial_out_oe_o}, 16'h0000);
    wr(16'h5c00);
    chk(pwr, 8'hff);
    host_u.xfer(32'h0000ac00, 8, rd);
    tick(8);
    chk(pwr, 8'hff);
    wr(16'hac0f);
    chk(pwr, 8'h0f);
    for (int i = 0; i < 3; i++) begin
      den = 3'h1 << i;
      tick(5);
      chk(pwr, 8'h0f | (8'h20 << i));
    end
    den = 3'h0;
    tick(5);
    chk(pwr, 8'h0f);
    wr(16'hace0);
    den = 3'h5;
    tick(5);
    chk(pwr, 8'he0);
    den = 3'h0;
    wr(16'haa0f);
    chk(lim, 8'h0f);
    wr(16'hac0f);
    // Over-temperature on channel three, then read back and echo
    fr.overtemp    = 8'h04;
    fr.overcurrent = 8'h02; // Channel two is in linear limiting, so it stays on
    tick(FC + 8);
    chk(pwr, 8'h0b);
    chk(pwr & 8'h02, 8'h02);
    chk(flt, 16'h0006);
    fork
      host_u.xfer(32'hac0fac0f, 32, rd);
      begin
        tick(30);
        chk({15'h0000, serial_out_oe_o}, 16'h0001);
      end
    join
    chk(rd[15:0], 16'h0006);
    chk(rd[31:16], 16'hac0f);
    tick(1);
    fr = '0;
    tick(10);
    chk(flt, 16'h0000);
    chk(pwr, 8'h0f);
    // Latched overcurrent switch-off on channel one
    wr(16'haa00);
    wr(16'ha301);
    fr.overcurrent = 8'h01;
    tick(FC + 8);
    chk(pwr, 8'h0e);
    fr = '0;
    tick(8);
    chk(flt, 16'h0001);
    // A frame with no clocks must leave latched faults alone
    host_u.xfer(32'h00000000, 0, rd);
    tick(8);
    chk(flt, 16'h0001);
    wr(16'hac0f);
    chk(flt, 16'h0000);
    chk(pwr, 8'h0f);
    // Off-state checks, masked on channels that are on
    fr.open_load  = 8'h11;
    fr.short_bat  = 8'ha0;
    fr.high_side  = 8'h20;
    fr.short_gnd  = 8'h42;
    tick(FC + 8);
    chk(flt, 16'h7000);
    chk({15'h0000, flt[13]}, 16'h0001);
    fr = '0;
    wr(16'haaff);
    res_n_i = 1'b0;
    tick(4);
    chk(pwr, 8'h00);
    res_n_i = 1'b1;
    tick(6);
    chk({pwr, lim}, 16'h0000);
    wrap_up();
  end
endmodule
